// File: rtl/sfd_pkg.sv
/*
 * sfd_pkg: constants, state codes and carrier structs of the speech
 * channel fec decoder.
 * assumes: referenced only by full scope, never imported.
 */
package sfd_pkg;
    // block geometry, normal slot first, frame stealing second
    localparam logic [9:0] NRM_IN = 10'h1B0;  // type-1 bits per slot
    localparam logic [9:0] STL_IN = 10'h0D8;  // second half slot only
    localparam logic [9:0] NRM_C0 = 10'h066;  // uncoded class bits
    localparam logic [9:0] STL_C0 = 10'h033;
    localparam logic [9:0] NRM_N1 = 10'h0A8;  // received bits at rate 2/3
    localparam logic [9:0] STL_N1 = 10'h054;
    localparam logic [9:0] NRM_N2 = 10'h0A2;  // received bits at 8/18
    localparam logic [9:0] STL_N2 = 10'h051;  // received bits at 8/17
    localparam logic [9:0] NRM_K1 = 10'h070;  // decoded bits, section one
    localparam logic [9:0] STL_K1 = 10'h038;
    localparam logic [9:0] NRM_KD = 10'h0B8;  // decoded bits, all
    localparam logic [9:0] STL_KD = 10'h05E;
    localparam logic [9:0] NRM_CL1 = 10'h064; // class 1 bits delivered
    localparam logic [9:0] STL_CL1 = 10'h030;
    localparam logic [9:0] NRM_CL2 = 10'h048; // crc protected class
    localparam logic [9:0] STL_CL2 = 10'h026;
    localparam logic [9:0] STL_FILL_N = 10'h022; // fixed bits appended
    // fixed values of the untransmitted bits, first bit at the top
    localparam logic [33:0] STL_FILL = 34'h2_14F4_D1C9;
    localparam logic [9:0] IL_ROWS = 10'h012; // deinterleaver matrix
    localparam logic [9:0] IL_COLS = 10'h018;
    // puncturing tables, the 8/18 table is a prefix of the 8/17 one
    localparam logic [9:0] P23_T = 10'h003;
    localparam logic [9:0] P23_PER = 10'h006;
    localparam logic [4:0] P23_TAB [3] = '{5'h01, 5'h02, 5'h04};
    localparam logic [9:0] P818_T = 10'h009;
    localparam logic [9:0] P818_PER = 10'h00C;
    localparam logic [9:0] P817_T = 10'h011;
    localparam logic [9:0] P817_PER = 10'h018;
    localparam logic [4:0] P817_TAB [17] = '{5'h01, 5'h02, 5'h03, 5'h04,
        5'h05, 5'h07, 5'h08, 5'h0A, 5'h0B, 5'h0D, 5'h0E, 5'h10, 5'h11,
        5'h13, 5'h14, 5'h16, 5'h17};
    localparam logic [6:0] CRC7_POLY = 7'h09; // low terms of 1+x^3+x^7
    localparam logic [3:0] CRC4_POLY = 4'h3;  // low terms of 1+x+x^4
    localparam logic [7:0] CHK_MASK_NRM = 8'hFF;
    localparam logic [7:0] CHK_MASK_STL = 8'h0F;
    localparam logic [3:0] VIT_START = 4'h0;  // encoder flushed to zero
    localparam logic [9:0] PM_INIT = 10'h100; // metric of unused states
    localparam logic [7:0] LUT_N = 8'hD8;     // stealing table entries
    localparam int V_LEN = 552;               // de-punctured positions
    localparam int KD_MAX = 184;
    localparam int IN_MAX = 432;

    typedef enum logic [2:0] {
        ST_LOAD  = 3'h0,
        ST_CLEAR = 3'h1,
        ST_DEPUN = 3'h3,
        ST_ACS   = 3'h2,
        ST_TRACE = 3'h6,
        ST_CRC   = 3'h7,
        ST_EMIT  = 3'h5
    } sfd_state_e;

    typedef struct packed {
        logic valid;
        logic data;
    } sfd_in_s;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] idx;
    } sfd_lut_s;

    typedef struct packed {
        logic valid;
        logic data;
        logic done;
        logic bfi;
    } sfd_out_s;
endpackage

// File: rtl/sfd_decoder.sv
/*
 * sfd_decoder: receive side fec decoder of the full rate speech channel,
 * one block at a time: load, deinterleave, de-puncture, viterbi, crc,
 * then deliver the classes and the bad frame flag serially.
 * assumes: the source and sink run on clk_sys_i; the sink never stalls.
 */
// Summary of operation
// - normal mode takes 432 bits per block
// - stealing mode takes 216 bits, mode-dependent strategy
// - stealing fills bits 62 to 82 fixed
// - stealing fills bits 83 to 95 fixed
// - normal reorder by 18 by 24 transposition
// - first 102 bits pass undecoded
// - then 168 at 2/3, 162 at 8/18
// - de-puncture by period and table positions
// - rate 2/3 positions 1,2,4, period 6
// - rate 8/18 nine positions, period 12
// - 16-state rate 1/3 viterbi decoding
// - generators in order G1, G2, G3
// - normal crc 1+x^3+x^7 over 72 bits
// - eighth check bit is overall parity
// - systematic crc, first bit lowest order
// - any check mismatch sets bad frame flag
// - deliver classes and flag, no check/tail
// - all stages finish before output starts
// - stealing splits 51, 84 at 2/3, 81
// - rate 8/17 seventeen positions, period 24
// - stealing crc 1+x+x^4 over 38 bits
`timescale 1ns/10ps
module sfd_decoder #(
    parameter int unsigned MET_W = 10 // path metric width
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic steal_i,             // frame stealing status
    input wire sfd_pkg::sfd_in_s in_i,    // type-1 bit with strobe
    output logic in_ready_o,              // block is taking bits
    input wire sfd_pkg::sfd_lut_s lut_i,  // stealing reorder table write
    output sfd_pkg::sfd_out_s out_o       // delivered bits and flag
);
    sfd_pkg::sfd_state_e state_q, state_d;
    logic steal_q;                        // mode of the current block
    logic [9:0] cnt_q, cnt_d;             // shared step counter
    logic [sfd_pkg::IN_MAX-1:0] in_buf_q; // type-1 bits as received
    logic [7:0] lut_q [216];              // stealing reorder table
    logic [sfd_pkg::V_LEN-1:0] v_ok_q;    // position was received
    logic [sfd_pkg::V_LEN-1:0] v_val_q;   // received hard bit
    logic [MET_W-1:0] pm_q [16];          // path metrics
    logic [MET_W-1:0] pm_new [16];
    logic [15:0] surv_q [sfd_pkg::KD_MAX];// survivor decisions per step
    logic [15:0] dec_bits;
    logic [sfd_pkg::KD_MAX-1:0] dec_q;    // decoded type-3 bits
    logic [3:0] tb_st_q;                  // traceback state
    logic [6:0] crc_q;
    logic par_q;
    logic bfi_q;
    sfd_pkg::sfd_out_s out_q;

    // column-major read of the 18 by 24 matrix
    function automatic logic [9:0] perm_norm(input logic [9:0] k);
        logic [9:0] r;
        logic [9:0] q;
        r = k % sfd_pkg::IL_ROWS;
        q = k / sfd_pkg::IL_ROWS;
        return 10'(r * sfd_pkg::IL_COLS + q);
    endfunction

    // mother code outputs {g3,g2,g1}; s[0] is the newest past bit
    function automatic logic [2:0] enc_out(input logic [3:0] s,
                                           input logic u);
        logic g1;
        logic g2;
        logic g3;
        g1 = u ^ s[0] ^ s[1] ^ s[2] ^ s[3];
        g2 = u ^ s[0] ^ s[2] ^ s[3];
        g3 = u ^ s[1] ^ s[3];
        return {g3, g2, g1};
    endfunction

    // hamming cost; erased positions cost nothing either way
    function automatic logic [1:0] branch_cost(input logic [2:0] ok,
                                               input logic [2:0] rx,
                                               input logic [2:0] ex);
        logic [2:0] d;
        d = (rx ^ ex) & ok;
        return 2'({1'b0, d[0]} + {1'b0, d[1]} + {1'b0, d[2]});
    endfunction

    // one division step, highest order coefficient fed first
    function automatic logic [6:0] crc_step(input logic [6:0] r,
                                            input logic din,
                                            input logic stl);
        logic fb;
        logic [3:0] r4;
        if (stl) begin
            fb = din ^ r[3];
            r4 = {r[2:0], 1'b0} ^ (fb ? sfd_pkg::CRC4_POLY : 4'h0);
            return {3'h0, r4};
        end
        fb = din ^ r[6];
        return {r[5:0], 1'b0} ^ (fb ? sfd_pkg::CRC7_POLY : 7'h00);
    endfunction

    // per-mode geometry, fixed for the block once the first bit lands
    wire [9:0] n_in = steal_q ? sfd_pkg::STL_IN : sfd_pkg::NRM_IN;
    wire [9:0] c0 = steal_q ? sfd_pkg::STL_C0 : sfd_pkg::NRM_C0;
    wire [9:0] n1 = steal_q ? sfd_pkg::STL_N1 : sfd_pkg::NRM_N1;
    wire [9:0] n2 = steal_q ? sfd_pkg::STL_N2 : sfd_pkg::NRM_N2;
    wire [9:0] k1 = steal_q ? sfd_pkg::STL_K1 : sfd_pkg::NRM_K1;
    wire [9:0] kd = steal_q ? sfd_pkg::STL_KD : sfd_pkg::NRM_KD;
    wire [9:0] cl1 = steal_q ? sfd_pkg::STL_CL1 : sfd_pkg::NRM_CL1;
    wire [9:0] cl2 = steal_q ? sfd_pkg::STL_CL2 : sfd_pkg::NRM_CL2;
    wire [9:0] n_fill = steal_q ? sfd_pkg::STL_FILL_N : 10'h000;
    wire [9:0] n_out = c0 + cl1 + cl2 + n_fill;

    // de-puncture address of received coded bit cnt_q
    wire dp_s2 = cnt_q >= n1;
    wire [9:0] dp_jj = dp_s2 ? cnt_q - n1 : cnt_q;
    wire [9:0] dp_t = !dp_s2 ? sfd_pkg::P23_T :
        (steal_q ? sfd_pkg::P817_T : sfd_pkg::P818_T);
    wire [9:0] dp_per = !dp_s2 ? sfd_pkg::P23_PER :
        (steal_q ? sfd_pkg::P817_PER : sfd_pkg::P818_PER);
    wire [9:0] dp_q = dp_jj / dp_t;
    wire [9:0] dp_r = dp_jj - 10'(dp_q * dp_t);
    wire [4:0] dp_p = dp_s2 ? sfd_pkg::P817_TAB[dp_r[4:0]] :
        sfd_pkg::P23_TAB[dp_r[1:0]];
    // section two continues the trellis right after section one
    wire [9:0] dp_off = dp_s2 ? 10'(k1 * 10'h003) : 10'h000;
    wire [9:0] dp_k = dp_off + 10'(dp_per * dp_q) + {5'h00, dp_p}
        - 10'h001;

    // type-2 position read through the deinterleaver
    wire [9:0] t2_pos = (state_q == sfd_pkg::ST_DEPUN) ? c0 + cnt_q : cnt_q;
    wire [9:0] t1_pos = steal_q ? {2'h0, lut_q[t2_pos[7:0]]} :
        perm_norm(t2_pos);
    wire t2_bit = in_buf_q[t1_pos[8:0]];

    // three de-punctured positions feed one trellis step
    wire [9:0] sym_base = 10'(cnt_q * 10'h003);
    wire [2:0] sym_ok = v_ok_q[sym_base +: 3];
    wire [2:0] sym_val = v_val_q[sym_base +: 3];

    // crc walks the protected class from its last bit down
    wire [9:0] crc_pos = cl1 + cnt_q;
    wire crc_din = dec_q[crc_pos[7:0]];
    wire [6:0] crc_nx = crc_step(crc_q, crc_din, steal_q);
    wire par_nx = par_q ^ crc_din;
    wire [7:0] chk_calc = steal_q ? {4'h0, crc_nx[3:0]} :
        {par_nx ^ (^crc_nx), crc_nx};
    wire [9:0] chk_base = cl1 + cl2;
    wire [7:0] chk_rx = dec_q[chk_base[7:0] +: 8];
    wire [7:0] chk_mask = steal_q ? sfd_pkg::CHK_MASK_STL :
        sfd_pkg::CHK_MASK_NRM;
    wire bfi_nx = |((chk_rx ^ chk_calc) & chk_mask);

    // delivered bit: class 0, then decoded classes, then fixed fill
    wire [9:0] em_dec = cnt_q - c0;
    wire [9:0] em_fill = em_dec - cl1 - cl2;
    wire [9:0] fill_ix = sfd_pkg::STL_FILL_N - 10'h001 - em_fill;
    wire em_last = cnt_q == n_out - 10'h001;
    wire em_bit = (cnt_q < c0) ? t2_bit :
        (em_dec < cl1 + cl2) ? dec_q[em_dec[7:0]] :
        sfd_pkg::STL_FILL[fill_ix[5:0]];

    assign in_ready_o = state_q == sfd_pkg::ST_LOAD;
    assign out_o = out_q;

    // add-compare-select over all 16 states in one cycle
    always_comb begin
        logic [3:0] p0;
        logic [3:0] p1;
        logic [MET_W-1:0] m0;
        logic [MET_W-1:0] m1;
        p0 = '0;
        p1 = '0;
        m0 = '0;
        m1 = '0;
        dec_bits = '0;
        for (int n = 0; n < 16; n++) begin
            p0 = {1'b0, 3'(n >> 1)};
            p1 = {1'b1, 3'(n >> 1)};
            m0 = pm_q[p0] + MET_W'(branch_cost(sym_ok, sym_val,
                enc_out(p0, n[0])));
            m1 = pm_q[p1] + MET_W'(branch_cost(sym_ok, sym_val,
                enc_out(p1, n[0])));
            dec_bits[n] = m1 < m0;
            pm_new[n] = (m1 < m0) ? m1 : m0;
        end
    end

    // sequencing: each stage runs to its end before the next one
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            sfd_pkg::ST_LOAD: begin
                if (in_i.valid) begin
                    if (cnt_q == n_in - 10'h001) begin
                        state_d = sfd_pkg::ST_CLEAR;
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + 10'h001;
                    end
                end
            end
            sfd_pkg::ST_CLEAR: begin
                state_d = sfd_pkg::ST_DEPUN;
            end
            sfd_pkg::ST_DEPUN: begin
                if (cnt_q == n1 + n2 - 10'h001) begin
                    state_d = sfd_pkg::ST_ACS;
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q + 10'h001;
                end
            end
            sfd_pkg::ST_ACS: begin
                if (cnt_q == kd - 10'h001) begin
                    state_d = sfd_pkg::ST_TRACE;
                end else begin
                    cnt_d = cnt_q + 10'h001;
                end
            end
            sfd_pkg::ST_TRACE: begin
                if (cnt_q == 10'h000) begin
                    state_d = sfd_pkg::ST_CRC;
                    cnt_d = cl2 - 10'h001;
                end else begin
                    cnt_d = cnt_q - 10'h001;
                end
            end
            sfd_pkg::ST_CRC: begin
                if (cnt_q == 10'h000) begin
                    state_d = sfd_pkg::ST_EMIT;
                end else begin
                    cnt_d = cnt_q - 10'h001;
                end
            end
            sfd_pkg::ST_EMIT: begin
                if (em_last) begin
                    state_d = sfd_pkg::ST_LOAD;
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q + 10'h001;
                end
            end
            default: begin
                // unused code, return to a safe idle
                state_d = sfd_pkg::ST_LOAD;
                cnt_d = '0;
            end
        endcase
    end

    // state, counter and the mode caught with the first bit
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_q <= sfd_pkg::ST_LOAD;
            cnt_q <= '0;
            steal_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            if (in_ready_o && in_i.valid && cnt_q == 10'h000) begin
                steal_q <= steal_i;
            end
        end
    end

    // input store, written only while the block is loading
    always_ff @(posedge clk_sys_i) begin
        if (in_ready_o && in_i.valid) begin
            in_buf_q[cnt_q[8:0]] <= in_i.data;
        end
    end

    // reorder table; reset to identity, rewrite it only between blocks
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 216; i++) begin
                lut_q[i] <= 8'(i);
            end
        end else if (lut_i.we && lut_i.addr < sfd_pkg::LUT_N) begin
            lut_q[lut_i.addr] <= lut_i.idx;
        end
    end

    // zero-filled mother block, then one received bit per cycle
    always_ff @(posedge clk_sys_i) begin
        if (state_q == sfd_pkg::ST_CLEAR) begin
            v_ok_q <= '0;
            v_val_q <= '0;
        end else if (state_q == sfd_pkg::ST_DEPUN) begin
            v_ok_q[dp_k] <= 1'b1;
            v_val_q[dp_k] <= t2_bit;
        end
    end

    // metrics start in state zero; width covers the worst block
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || state_q == sfd_pkg::ST_CLEAR) begin
            for (int n = 0; n < 16; n++) begin
                pm_q[n] <= (n == 0) ? '0 : MET_W'(sfd_pkg::PM_INIT);
            end
        end else if (state_q == sfd_pkg::ST_ACS) begin
            pm_q <= pm_new;
            surv_q[cnt_q[7:0]] <= dec_bits;
        end
    end

    // traceback from the flushed zero state, newest bit first
    always_ff @(posedge clk_sys_i) begin
        if (state_q == sfd_pkg::ST_ACS) begin
            tb_st_q <= sfd_pkg::VIT_START;
        end else if (state_q == sfd_pkg::ST_TRACE) begin
            dec_q[cnt_q[7:0]] <= tb_st_q[0];
            tb_st_q <= {surv_q[cnt_q[7:0]][tb_st_q], tb_st_q[3:1]};
        end
    end

    // crc and parity, verdict taken on the first class bit, which is fed last
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || state_q == sfd_pkg::ST_TRACE) begin
            crc_q <= '0;
            par_q <= 1'b0;
        end else if (state_q == sfd_pkg::ST_CRC) begin
            crc_q <= crc_nx;
            par_q <= par_nx;
        end
    end

    // bad frame flag holds until the next verdict
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            bfi_q <= 1'b0;
        end else if (state_q == sfd_pkg::ST_CRC && cnt_q == 10'h000) begin
            bfi_q <= bfi_nx;
        end
    end

    // registered delivery, one bit per cycle with no back-pressure
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            out_q <= '0;
        end else begin
            out_q.valid <= state_q == sfd_pkg::ST_EMIT;
            out_q.data <= (state_q == sfd_pkg::ST_EMIT) & em_bit;
            out_q.done <= (state_q == sfd_pkg::ST_EMIT) & em_last;
            out_q.bfi <= bfi_q;
        end
    end
endmodule

// File: tb/sfd_decoder_props.sv
/* sfd_decoder_props: port assertions of the decoder.
   assumes: one clock, synchronous active low reset, bound below. */
`timescale 1ns/10ps
module sfd_decoder_props (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic steal_i,
    input wire sfd_pkg::sfd_in_s in_i,
    input wire logic in_ready_o,
    input wire sfd_pkg::sfd_lut_s lut_i,
    input wire sfd_pkg::sfd_out_s out_o
);
    int in_cnt_q; // bits taken this block
    int out_cnt_q; // bits of this burst
    int lat_q;     // edges since loading stopped
    logic stl_q;   // mode of the block, latched with its first bit
    logic take;    // a bit is accepted at this edge
    int last_in;   // index of the final bit of the block
    assign take = in_ready_o && in_i.valid;
    assign last_in = stl_q ? 215 : 431;

    // block, burst and delay counters; mode known only after bit 0
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            in_cnt_q <= 0;
            out_cnt_q <= 0;
            lat_q <= 0;
            stl_q <= 1'b0;
        end else begin
            in_cnt_q <= !in_ready_o ? 0 : (take ? in_cnt_q + 1 : in_cnt_q);
            out_cnt_q <= out_o.done ? 0 : out_cnt_q + int'(out_o.valid);
            lat_q <= in_ready_o ? 0 : lat_q + 1;
            if (take && in_cnt_q == 0) begin
                stl_q <= steal_i;
            end
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence last_bit_s;
        take && in_cnt_q == last_in;
    endsequence
    sequence burst_end_s;
        out_o.valid && out_o.done;
    endsequence

    load_len_a: assert property (last_bit_s |=> !in_ready_o)
        else $error("load too long");
    load_early_a: assert property (
        take && in_cnt_q < last_in |=> in_ready_o)
        else $error("load too short");
    done_with_a: assert property (
        out_o.done |-> out_o.valid && in_ready_o)
        else $error("done without valid/ready");
    burst_len_a: assert property (
        burst_end_s |-> out_cnt_q == (stl_q ? 170 : 273))
        else $error("burst length");
    ans_delay_a: assert property (
        $rose(out_o.valid) |-> lat_q == (stl_q ? 393 : 772))
        else $error("answer delay");
    busy_hold_a: assert property ($rose(in_ready_o) |-> out_o.done)
        else $error("ready before done");
    out_busy_a: assert property (
        out_o.valid && !out_o.done |-> !in_ready_o)
        else $error("output while loading");
    burst_run_a: assert property ($fell(out_o.valid) |-> $past(out_o.done))
        else $error("burst broken before done");
    idle_zero_a: assert property (
        !out_o.valid |-> !out_o.data && !out_o.done)
        else $error("data or done without valid");
    flag_hold_a: assert property ($changed(out_o.bfi) |-> $rose(out_o.valid))
        else $error("flag changed off slot");
endmodule

bind sfd_decoder sfd_decoder_props sfd_decoder_props_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .steal_i(steal_i),
    .in_i(in_i), .in_ready_o(in_ready_o), .lut_i(lut_i), .out_o(out_o));

// File: tb/sfd_src_model.sv
/* sfd_src_model: demodulator stand-in that encodes class bits into
   type-1 blocks and offers them one bit per strobe.
   assumes: bench fills c0, dec, map and flip, then build and send. */
`timescale 1ns/10ps
module sfd_src_model (
    input wire logic clk_sys_i,
    input wire logic in_ready_i,
    output sfd_pkg::sfd_in_s in_o,
    output logic steal_o
);
    logic c0 [102];  // uncoded class bits
    logic dec [184]; // classes, checks and tail before encoding
    logic t1 [432];  // type-1 bits as offered
    int map [216];   // stealing reorder: type-2 position to type-1 index
    int flip [$];    // type-2 positions hit by channel errors
    int p23 [3] = '{1, 2, 4};
    int ptab [17] = '{1, 2, 3, 4, 5, 7, 8, 10, 11,
        13, 14, 16, 17, 19, 20, 22, 23};

    initial begin
        in_o = '0;
        steal_o = 1'b0;
        foreach (map[p]) map[p] = p;
    end

    // check bits, encode, puncture, errors, reorder
    task automatic build(input bit stl, input logic [7:0] bad);
        logic [6:0] r;
        logic [3:0] s;
        logic fb;
        logic v [552];
        logic t2 [432];
        int k1, kc, b, n1, n2, nc, per, t;
        k1 = stl ? 56 : 112;
        kc = stl ? 48 : 100;
        b = kc + (stl ? 38 : 72);
        n1 = stl ? 84 : 168;
        n2 = stl ? 81 : 162;
        nc = stl ? 51 : 102;
        per = stl ? 24 : 12;
        t = stl ? 17 : 9;
        r = 7'h00;
        // crc fed last class bit first, so bit 0 ends lowest order
        for (int i = b - 1; i >= kc; i--) begin
            fb = dec[i] ^ r[stl ? 3 : 6];
            r = ((r << 1) ^ (fb ? (stl ? 7'h03 : 7'h09) : 7'h00))
                & (stl ? 7'h0F : 7'h7F);
        end
        fb = ^r;
        for (int i = kc; i < b; i++) fb = fb ^ dec[i];
        for (int i = 0; i < (stl ? 4 : 7); i++) dec[b + i] = r[i] ^ bad[i];
        if (!stl) dec[b + 7] = fb ^ bad[7];
        for (int i = b + (stl ? 4 : 8); i < b + (stl ? 8 : 12); i++) begin
            dec[i] = 1'b0;
        end
        s = 4'h0;
        for (int n = 0; n < b + (stl ? 8 : 12); n++) begin
            v[3 * n] = dec[n] ^ (^s);
            v[3 * n + 1] = dec[n] ^ s[0] ^ s[2] ^ s[3];
            v[3 * n + 2] = dec[n] ^ s[1] ^ s[3];
            s = {s[2:0], dec[n]};
        end
        for (int i = 0; i < nc; i++) t2[i] = c0[i];
        for (int j = 0; j < n1; j++) begin
            t2[nc + j] = v[6 * (j / 3) + p23[j % 3] - 1];
        end
        for (int j = 0; j < n2; j++) begin
            t2[nc + n1 + j] = v[3 * k1 + per * (j / t) + ptab[j % t] - 1];
        end
        foreach (flip[e]) t2[flip[e]] = ~t2[flip[e]];
        for (int p = 0; p < 216 && stl; p++) t1[map[p]] = t2[p];
        for (int i = 0; i < 18 && !stl; i++) begin
            for (int j = 0; j < 24; j++) t1[i * 24 + j] = t2[j * 18 + i];
        end
    endtask

    // offer cnt bits; gaps idle the strobe, junk strobes while busy
    task automatic send(input bit stl, input bit gaps, input bit junk,
        input int cnt);
        for (int n = 0; n < cnt; n++) begin
            in_o <= '{valid: 1'b1, data: t1[n]};
            steal_o <= stl;
            do @(posedge clk_sys_i); while (!in_ready_i);
            if (gaps && n % 50 == 49) begin
                in_o <= '{valid: 1'b0, data: ~t1[n]};
                @(posedge clk_sys_i);
            end
        end
        if (junk) begin
            in_o <= '{valid: 1'b1, data: ~t1[0]};
            repeat (3) @(posedge clk_sys_i);
        end
        in_o <= '{valid: 1'b0, data: ~in_o.data};
    endtask
endmodule

// File: tb/sfd_decoder_tb_top.sv
/* sfd_decoder_tb_top: self-checking bench of the decoder.
   assumes: 100 MHz clock, sink takes every bit, model drives input. */
`timescale 1ns/10ps
module sfd_decoder_tb_top;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic steal_i;
    sfd_pkg::sfd_in_s in_i;
    logic in_ready_o;
    sfd_pkg::sfd_lut_s lut_i = '0;
    sfd_pkg::sfd_out_s out_o;
    int bad_count = 0;
    int total_checks = 0;
    int dones = 0; // done pulses
    logic got_q [$]; // delivered bits of the current block
    logic bfi_seen; // flag sampled with done

    always #5 clk_sys_i = ~clk_sys_i;

    sfd_decoder sfd_decoder_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .steal_i(steal_i), .in_i(in_i), .in_ready_o(in_ready_o),
        .lut_i(lut_i), .out_o(out_o));
    sfd_src_model sfd_src_model_i (.clk_sys_i(clk_sys_i),
        .in_ready_i(in_ready_o), .in_o(in_i), .steal_o(steal_i));

    // collect delivered bits and the flag at done
    always @(posedge clk_sys_i) begin
        if (out_o.valid) got_q.push_back(out_o.data);
        if (out_o.done) begin
            dones++;
            bfi_seen = out_o.bfi;
        end
    end

    task automatic chk_bit(input string what, input logic exp,
        input logic got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_num(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // one block through the decoder, judged bit by bit
    task automatic run_block(input bit stl, input bit gaps, input bit junk,
        input logic [7:0] bad, input logic exp_bfi, input int k);
        logic exp_q [$];
        int d0, w;
        d0 = dones;
        got_q.delete();
        foreach (sfd_src_model_i.c0[i]) sfd_src_model_i.c0[i] = (i*5+k)%7 < 3;
        foreach (sfd_src_model_i.dec[i]) sfd_src_model_i.dec[i] = (i*3+k)%11<5;
        for (int i = 0; i < (stl ? 51 : 102); i++) begin
            exp_q.push_back(sfd_src_model_i.c0[i]);
        end
        for (int i = 0; i < (stl ? 86 : 172); i++) begin
            exp_q.push_back(sfd_src_model_i.dec[i]);
        end
        for (int i = 33; i >= 0 && stl; i--) begin
            exp_q.push_back(sfd_pkg::STL_FILL[i]);
        end
        sfd_src_model_i.build(stl, bad);
        sfd_src_model_i.send(stl, gaps, junk, stl ? 216 : 432);
        w = 0;
        while (dones == d0 && w < 2000) begin
            @(posedge clk_sys_i);
            w++;
        end
        chk_num("done pulses", d0 + 1, dones);
        chk_num("bits delivered", exp_q.size(), got_q.size());
        for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
            chk_bit($sformatf("bit %0d", i), exp_q[i], got_q[i]);
        end
        chk_bit("bad frame flag", exp_bfi, bfi_seen);
        @(posedge clk_sys_i);
    endtask

    task automatic t_normal_clean();
        run_block(1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1);
    endtask

    // reset drops a partial block, outputs go quiet
    task automatic t_mid_reset();
        sfd_src_model_i.send(1'b0, 1'b0, 1'b0, 200);
        rst_n_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        chk_bit("ready in reset", 1'b1, in_ready_o);
        chk_bit("valid in reset", 1'b0, out_o.valid);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
    endtask

    // one error per coded section, strobe gaps, refused strobes
    task automatic t_normal_noisy();
        sfd_src_model_i.flip = '{150, 300};
        run_block(1'b0, 1'b1, 1'b1, 8'h00, 1'b0, 2);
        sfd_src_model_i.flip.delete();
    endtask

    // a wrong crc bit, then a wrong parity bit
    task automatic t_normal_checks();
        run_block(1'b0, 1'b0, 1'b0, 8'h40, 1'b1, 3);
        run_block(1'b0, 1'b0, 1'b0, 8'h80, 1'b1, 4);
    endtask

    task automatic t_steal_clean();
        run_block(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 5);
    endtask

    // reversed reorder table, then a wrong 4-bit crc
    task automatic t_steal_table();
        for (int p = 0; p < 216; p++) begin
            lut_i <= '{we: 1'b1, addr: 8'(p), idx: 8'(215 - p)};
            sfd_src_model_i.map[p] = 215 - p;
            @(posedge clk_sys_i);
        end
        lut_i.we <= 1'b0;
        @(posedge clk_sys_i);
        run_block(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 6);
        run_block(1'b1, 1'b1, 1'b0, 8'h08, 1'b1, 7);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog, blocks need under 20000 cycles
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        bad_count++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        t_normal_clean();
        t_mid_reset();
        t_normal_noisy();
        t_normal_checks();
        t_steal_clean();
        t_steal_table();
        complete_run();
    end
endmodule
